// *** bench/dtss_peer.sv ***
// Peripheral model: pulse source and serial partner on the shift lines
`timescale 1ns/1ps
module dtss_peer (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic line_oe_i,
  output logic pulse_o,
  output logic sclk_o,
  output logic sdata_o
);
  logic [7:0] sh = 8'h00;
  logic first = 1'b0;
  logic last = 1'b1;
  int rises = 0;
  int hi_len = 0;
  int hi_cnt = 0;
  initial begin
    pulse_o = 1'b1;
    sclk_o = 1'b1;
  end
  assign sdata_o = sh[7];
  ////////////////////////////////////////////////////////////////////////////////
  // First fall keeps the MSB; later falls move on, well before the next rise
  always @(posedge clk_i) begin
    last <= line_i;
    if (line_oe_i && last && !line_i) begin
      hi_len <= hi_cnt;
      if (first)
        first <= 1'b0;
      else
        sh <= {sh[6:0], ~sh[0]};
    end
    if (line_oe_i && !last && line_i)
      rises <= rises + 1;
    hi_cnt <= line_i ? hi_cnt + 1 : 0;
  end
  task automatic load(input logic [7:0] b);
    sh = b;
    first = 1'b1;
    rises = 0;
  endtask
  // Low for four clocks so a sampling edge always sees it
  task automatic pulses(input int k);
    repeat (k) begin
      #16 pulse_o = 1'b0;
      #16 pulse_o = 1'b1;
    end
  endtask
  // Link clock runs only inside the frame
  task automatic ext(input logic [7:0] b);
    sh = b;
    for (int i = 0; i < 8; i++) begin
      sclk_o = 1'b0;
      if (i > 0)
        sh = {sh[6:0], ~sh[0]};
      #40 sclk_o = 1'b1;
      #40;
    end
  endtask
endmodule // dtss_peer

// *** bench/dtss_props.sv ***
// Concurrent checks on the ports of the dual timer and serial shifter
`timescale 1ns/1ps
`include "dtss_consts.svh"
module dtss_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`DTSS_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic port_b_top_pin_oe_o,
  input wire logic port_b_shift_clock_line_oe_o,
  input wire logic [7:0] t1_flag_t2_flag_sr_flag_o
);
  logic req;
  logic w;
  logic r;
  logic [7:0] fl;
  // A request counts once, on the edge that takes it
  assign req = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
  assign w = req & wb_we_i & wb_sel_i[0];
  assign r = req & !wb_we_i;
  assign fl = t1_flag_t2_flag_sr_flag_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  pin_dir_a: assert property (
    w && wb_adr_i == `DTSS_OFF_PORT_B_DIRECTION_REG |=> port_b_top_pin_oe_o == $past(wb_dat_i[7]))
    else $error("pin enable does not follow direction bit");
  sclk_dir_a: assert property (
    w && wb_adr_i == `DTSS_OFF_ACR |=> port_b_shift_clock_line_oe_o == ($past(wb_dat_i[4:2]) == 3'h1))
    else $error("shift clock drive does not follow mode");
  sr_held_a: assert property (
    !port_b_shift_clock_line_oe_o && !$past(port_b_shift_clock_line_oe_o)
    && !$past(port_b_shift_clock_line_oe_o, 2) |-> !fl[2])
    else $error("shifter flag set in external clock mode");
  t1_start_a: assert property (w && wb_adr_i == `DTSS_OFF_T1CH |-> ##2 !fl[6])
    else $error("first flag kept after high count write");
  t1_clear_a: assert property (
    (w && wb_adr_i == `DTSS_OFF_T1LH) || (r && wb_adr_i == `DTSS_OFF_T1CL) |-> ##2 !fl[6])
    else $error("first flag kept after clearing access");
  t2_clear_a: assert property (
    (w && wb_adr_i == `DTSS_OFF_T2CH) || (r && wb_adr_i == `DTSS_OFF_T2CL) |-> ##2 !fl[5])
    else $error("second flag kept after clearing access");
  flag_wr_a: assert property (
    w && wb_adr_i == `DTSS_OFF_IFR |-> ##2 (fl & $past(wb_dat_i[7:0], 2) & 8'h64) == 8'h00)
    else $error("flag write of one did not clear");
  sr_done_a: assert property ($rose(fl[2]) |-> port_b_shift_clock_line_oe_o)
    else $error("shifter flag rose outside generated clock mode");
endmodule // dtss_props
bind dtss_top dtss_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .wb_err_o, .port_b_top_pin_oe_o, .port_b_shift_clock_line_oe_o,
  .t1_flag_t2_flag_sr_flag_o);

// *** bench/test_dtss_top.sv ***
// Self-checking bench for the dual timer and serial shifter
`timescale 1ns/1ps
`include "dtss_consts.svh"
module test_dtss_top;
  typedef struct packed {
    logic [5:0] adr;
    logic [7:0] wd;
    logic [7:0] rd;
    logic err;
  } dtss_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [3:0] s = 4'h1;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wb_err_o, port_b_top_pin_o, port_b_top_pin_oe_o, port_b_pulse_input_pin_i;
  logic port_b_shift_clock_line_i, port_b_shift_clock_line_o, port_b_shift_clock_line_oe_o;
  logic port_b_serial_data_line_i, peer_clk, e;
  logic [7:0] f, q;
  int n, check_count = 0, n_fail = 0;
  dtss_row_t rows [5] = '{'{`DTSS_OFF_ORB, 8'ha5, 8'ha5, 1'b0}, '{`DTSS_OFF_PORT_B_DIRECTION_REG, 8'h3c, 8'h3c, 1'b0},
    '{`DTSS_OFF_ACR, 8'he0, 8'he0, 1'b0}, '{6'h30, 8'h11, 8'h00, 1'b1}, '{6'h01, 8'h22, 8'h00, 1'b1}};
  assign port_b_shift_clock_line_i = port_b_shift_clock_line_oe_o ? port_b_shift_clock_line_o : peer_clk;
  dtss_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .wb_err_o, .port_b_top_pin_i(port_b_top_pin_o), .port_b_top_pin_o, .port_b_top_pin_oe_o,
    .port_b_pulse_input_pin_i, .port_b_shift_clock_line_i, .port_b_shift_clock_line_o,
    .port_b_shift_clock_line_oe_o, .port_b_serial_data_line_i, .t1_flag_t2_flag_sr_flag_o(f));
  dtss_peer u_peer (.clk_i, .line_i(port_b_shift_clock_line_i), .line_oe_i(port_b_shift_clock_line_oe_o),
    .pulse_o(port_b_pulse_input_pin_i), .sclk_o(peer_clk), .sdata_o(port_b_serial_data_line_i));
  always #2 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    check_count++;
    if (y !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic chr(input string nm, input logic [31:0] v, input int lo, input int hi);
    check_count++;
    if ((v >= lo && v <= hi) !== 1'b1) begin
      n_fail++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask
  // Holds the request until the edge that samples the answer
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20);
    q = wb_dat_o[7:0];
    e = wb_err_o;
    chk("answer", 1'b1, wb_ack_o | wb_err_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a);
    wb(1'b0, a, 8'h00);
  endtask
  task automatic wait_bit(input int b, input int lim);
    n = 0;
    while (f[b] !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      #1 n++;
    end
  endtask
  task automatic wait_tog();
    logic p;
    p = port_b_top_pin_o;
    n = 0;
    while (port_b_top_pin_o === p && n < 200) begin
      @(posedge clk_i);
      #1 n++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(rows[i].adr, rows[i].wd);
      chk("err", rows[i].err, e);
      if (!rows[i].err) begin
        rd(rows[i].adr);
        chk("readback", rows[i].rd, q);
      end
    end
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk("rst flags", 8'h00, f);
    chk("rst pin", 2'b00, {port_b_top_pin_o, port_b_top_pin_oe_o});
    chk("rst sclk", 2'b10, {port_b_shift_clock_line_o, port_b_shift_clock_line_oe_o});
    s = 4'h0;
    wr(`DTSS_OFF_ORB, 8'hff);
    s = 4'h1;
    rd(`DTSS_OFF_ORB);
    chk("no lane", 8'h00, q);
    // One-shot pulse on the top pin while the output register holds one
    wr(`DTSS_OFF_ORB, 8'h80);
    wr(`DTSS_OFF_PORT_B_DIRECTION_REG, 8'h80);
    wr(`DTSS_OFF_ACR, 8'h80);
    wr(`DTSS_OFF_T1CL, 8'h10);
    wr(`DTSS_OFF_T1CH, 8'h00);
    chk("pin", 1'b0, port_b_top_pin_o);
    wait_bit(6, 40);
    chr("t1 len", n, 14, 18);
    chk("pin", 1'b1, port_b_top_pin_o);
    wr(`DTSS_OFF_ORB, 8'h00);
    chk("pin", 1'b1, port_b_top_pin_o);
    wr(`DTSS_OFF_ACR, 8'h00);
    chk("pin", 1'b0, port_b_top_pin_o);
    wr(`DTSS_OFF_IFR, 8'h40);
    repeat (40) @(posedge clk_i);
    #1 chk("t1 once", 1'b0, f[6]);
    wr(`DTSS_OFF_T1CH, 8'h00);
    wait_bit(6, 40);
    rd(`DTSS_OFF_T1CL);
    @(posedge clk_i);
    #1 chk("t1 rd clr", 1'b0, f[6]);
    wr(`DTSS_OFF_T1CH, 8'h00);
    wait_bit(6, 40);
    wr(`DTSS_OFF_T1LH, 8'h00);
    @(posedge clk_i);
    #1 chk("t1 lh clr", 1'b0, f[6]);
    // Free run: spacing follows the latch, a latch write waits for the next period
    wr(`DTSS_OFF_ACR, 8'hc0);
    wr(`DTSS_OFF_T1CL, 8'h08);
    wr(`DTSS_OFF_T1CH, 8'h00);
    wait_tog();
    wait_tog();
    chr("t1 half", n, 9, 10);
    wr(`DTSS_OFF_IFR, 8'h40);
    wait_bit(6, 12);
    chk("t1 again", 1'b1, f[6]);
    wr(`DTSS_OFF_T1CL, 8'h20);
    wait_tog();
    chr("t1 cur", n, 0, 10);
    wait_tog();
    chr("t1 next", n, 33, 34);
    wr(`DTSS_OFF_ACR, 8'h00);
    wr(`DTSS_OFF_T2CL, 8'h80);
    wr(`DTSS_OFF_T2CH, 8'h12);
    rd(`DTSS_OFF_T2CH);
    chk("t2 hi", 8'h12, q);
    rd(`DTSS_OFF_T2CL);
    chr("t2 lo", q, 8'h70, 8'h7f);
    wr(`DTSS_OFF_T2CH, 8'h00);
    wait_bit(5, 200);
    chr("t2 len", n, 126, 132);
    rd(`DTSS_OFF_T2CL);
    @(posedge clk_i);
    #1 chk("t2 clr", 1'b0, f[5]);
    // Pulse counting: the clock alone must not reach zero in this time
    wr(`DTSS_OFF_ACR, 8'h20);
    wr(`DTSS_OFF_T2CL, 8'h03);
    wr(`DTSS_OFF_T2CH, 8'h00);
    u_peer.pulses(3);
    repeat (8) @(posedge clk_i);
    #1 chk("t2 cnt", 1'b0, f[5]);
    u_peer.pulses(1);
    repeat (8) @(posedge clk_i);
    #1 chk("t2 cnt", 1'b1, f[5]);
    rd(`DTSS_OFF_T2CL);
    chk("t2 past", 8'hff, q);
    wr(`DTSS_OFF_ACR, 8'h04);
    wr(`DTSS_OFF_T2CL, 8'h02);
    u_peer.load(8'hb4);
    rd(`DTSS_OFF_SR);
    wr(`DTSS_OFF_T2CH, 8'h00);
    wait_bit(2, 400);
    chk("sr rises", 8, u_peer.rises);
    chk("sr half", 4, u_peer.hi_len);
    u_peer.load(8'h69);
    rd(`DTSS_OFF_SR);
    chk("sr data", 8'hb4, q);
    wait_bit(2, 150);
    rd(`DTSS_OFF_SR);
    chk("sr at once", 8'h69, q);
    wr(`DTSS_OFF_ACR, 8'h00);
    u_peer.ext(8'h5a);
    repeat (4) @(posedge clk_i);
    rd(`DTSS_OFF_SR);
    chk("sr ext", 8'h5a, q);
    chk("sr flag", 1'b0, f[2]);
    print_verdict();
  end
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end
endmodule // test_dtss_top

// *** hw/dtss_consts.svh ***
// Register offsets, field positions, reset values and counts for the dual timer and serial shifter
// Operation
// R01 - First timer: two 8-bit reload latches and a 16-bit counter decrementing each clock.
// R02 - Low counter byte not writable; loaded from low latch on high counter write.
// R03 - High counter write clears flag, copies low latch, starts countdown.
// R04 - One-shot: at zero set flag once, keep decrementing, no re-set until cleared.
// R05 - One-shot with pin enable: top pin low after high write, high at time-out.
// R06 - One-shot: high latch write does not disturb current operation.
// R07 - Free-run: each zero sets flag, toggles pin, reloads all 16 latch bits.
// R08 - First flag cleared by high count write, high latch write, low count read, flag write.
// R09 - Latch writes set next period only; high counter write restarts period.
// R10 - Top pin carries timer only when direction bit 7 and enable bit both one.
// R11 - One control bit selects second timer one-shot or pulse counting.
// R12 - Second timer: write-only low latch, read-only low count, read/write high count.
// R13 - Second timer one-shot: one flag per high write, keeps decrementing.
// R14 - Second flag cleared by low count read or high count write.
// R15 - Pulse mode: decrement per falling pulse; flag once on passing below zero.
// R16 - Counted pulse must already be low at the sampling clock edge.
// R17 - Shifter moves serial data on data line, modulo-8 count, MSB first.
// R18 - Shift clock external on clock line or generated internally by mode.
// R19 - Mode 0: shifter flag held zero, shift in data on each clock line rise.
// R20 - Mode 1: device drives shift clocks, period from clock and second latch low N.
// R21 - Mode 1: access starts at once if flag set, else at next second timer time-out.
// R22 - Mode 1: sample data the cycle after rising edge; flag after 8 pulses.
// R23 - Timer modes are selected by bits of the aux control register.
// R24 - Writing one to a flag bit position clears that flag.
// R25 - High counter write also loads written value into counter high byte.
// R26 - Second low byte write stores only into its latch, moved on high write.
`ifndef DTSS_CONSTS_SVH
`define DTSS_CONSTS_SVH
`define DTSS_AW 6
`define DTSS_OFF_ORB 6'h00
`define DTSS_OFF_PORT_B_DIRECTION_REG 6'h08
`define DTSS_OFF_T1CL 6'h10
`define DTSS_OFF_T1CH 6'h14
`define DTSS_OFF_T1LL 6'h18
`define DTSS_OFF_T1LH 6'h1c
`define DTSS_OFF_T2CL 6'h20
`define DTSS_OFF_T2CH 6'h24
`define DTSS_OFF_SR 6'h28
`define DTSS_OFF_ACR 6'h2c
`define DTSS_OFF_IFR 6'h34
`define DTSS_ACR_T1PIN 7
`define DTSS_ACR_T1FREE 6
`define DTSS_ACR_T2PULSE 5
`define DTSS_ACR_SRM_HI 4
`define DTSS_ACR_SRM_LO 2
`define DTSS_IFR_T1 6
`define DTSS_IFR_T2 5
`define DTSS_IFR_SR 2
`define DTSS_PB_TOP 7
`define DTSS_BYTE_RST 8'h00
`define DTSS_WORD_RST 16'hffff
`define DTSS_BITS_PER_BYTE 3'h7
`define DTSS_SRM_EXT 3'h0
`define DTSS_SRM_T2IN 3'h1
`endif

// *** hw/dtss_pkg.sv ***
// Types shared by the dual timer and serial shifter
package dtss_pkg;
  typedef struct packed {
    logic pin_enable;
    logic free_run;
    logic t2_pulse;
    logic [2:0] sr_mode;
  } dtss_mode_t;
  typedef enum logic [1:0] {
    DTSS_SH_IDLE,
    DTSS_SH_WAIT,
    DTSS_SH_RUN
  } dtss_shift_state_t;
endpackage

// *** hw/dtss_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dtss_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '1;
      sync_o <= '1;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule // dtss_sync

// *** hw/dtss_timer16.sv ***
// 16-bit down counter with load and count enable
`timescale 1ns/1ps
`include "dtss_consts.svh"
module dtss_timer16 #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] load_value_i,
  input wire logic dec_i,
  output logic [WIDTH-1:0] count_o,
  output logic zero_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= `DTSS_WORD_RST;
    end else if (load_i) begin
      count_o <= load_value_i;
    end else if (dec_i) begin
      count_o <= count_o - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign zero_o = (count_o == '0);
endmodule // dtss_timer16

// *** hw/dtss_top.sv ***
// Dual interval timer and serial shifter with a classic Wishbone register slave
`timescale 1ns/1ps
`include "dtss_consts.svh"
module dtss_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`DTSS_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic port_b_top_pin_i,
  output logic port_b_top_pin_o,
  output logic port_b_top_pin_oe_o,
  input wire logic port_b_pulse_input_pin_i,
  input wire logic port_b_shift_clock_line_i,
  output logic port_b_shift_clock_line_o,
  output logic port_b_shift_clock_line_oe_o,
  input wire logic port_b_serial_data_line_i,
  output logic [7:0] t1_flag_t2_flag_sr_flag_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Software-visible registers
  logic [7:0] port_b_output_reg;
  logic [7:0] port_b_direction_reg;
  logic [7:0] first_timer_latch_low;
  logic [7:0] first_timer_latch_high;
  logic [7:0] second_timer_latch_low;
  logic [7:0] aux_control_reg;
  logic [7:0] serial_shifter;
  logic [7:0] interrupt_flag_reg;

  // Mode, timer and shifter state
  dtss_pkg::dtss_mode_t mode;
  dtss_pkg::dtss_shift_state_t sh_state_reg;
  logic [15:0] t1_count;
  logic [15:0] t2_count;
  logic t1_zero;
  logic t2_zero;
  logic t1_armed_reg;
  logic t2_armed_reg;
  logic t1_pin_reg;
  logic [2:0] sh_count_reg;
  logic sh_clk_reg;
  logic sh_sample_reg;
  logic [7:0] t2_half_reg;

  // Synchronised pins and their delayed copies
  logic pb6_s;
  logic pb6_d_reg;
  logic cb1_s;
  logic cb1_d_reg;
  logic cb2_s;

  // Bus decode
  logic ack_reg;
  logic req;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  // One-cycle events
  logic t1_timeout;
  logic t2_dec;
  logic t2_timeout;
  logic sr_access;
  logic sh_tick;

  function automatic logic hit(input logic [`DTSS_AW-1:0] adr, input logic [`DTSS_AW-1:0] off,
                               input logic en);
    hit = en && (adr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // They reset to the idle-high level: no false edge after reset
  dtss_sync #(.WIDTH(3)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({port_b_pulse_input_pin_i, port_b_shift_clock_line_i, port_b_serial_data_line_i}),
    .sync_o({pb6_s, cb1_s, cb2_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one-wait-state ack, byte lane 0 carries data
  // A pending err blocks the request too, so err stands one cycle
  assign req = wb_cyc_i && wb_stb_i && !ack_reg && !wb_err_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;

  assign wbyte = wb_dat_i[7:0];

  assign mapped = (wb_adr_i == `DTSS_OFF_ORB) || (wb_adr_i == `DTSS_OFF_PORT_B_DIRECTION_REG) ||
                  (wb_adr_i == `DTSS_OFF_T1CL) || (wb_adr_i == `DTSS_OFF_T1CH) ||
                  (wb_adr_i == `DTSS_OFF_T1LL) || (wb_adr_i == `DTSS_OFF_T1LH) ||
                  (wb_adr_i == `DTSS_OFF_T2CL) || (wb_adr_i == `DTSS_OFF_T2CH) ||
                  (wb_adr_i == `DTSS_OFF_SR) || (wb_adr_i == `DTSS_OFF_ACR) ||
                  (wb_adr_i == `DTSS_OFF_IFR);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      ack_reg <= req && mapped;
      wb_err_o <= req && !mapped;
    end
  end
  assign wb_ack_o = ack_reg;

  // Unmapped offsets read as zero
  always_comb begin
    rbyte = `DTSS_BYTE_RST;
    case (wb_adr_i)
      `DTSS_OFF_ORB: rbyte = port_b_output_reg;
      `DTSS_OFF_PORT_B_DIRECTION_REG: rbyte = port_b_direction_reg;
      `DTSS_OFF_T1CL: rbyte = t1_count[7:0];
      `DTSS_OFF_T1CH: rbyte = t1_count[15:8];
      `DTSS_OFF_T1LL: rbyte = first_timer_latch_low;
      `DTSS_OFF_T1LH: rbyte = first_timer_latch_high;
      `DTSS_OFF_T2CL: rbyte = t2_count[7:0];
      `DTSS_OFF_T2CH: rbyte = t2_count[15:8];
      `DTSS_OFF_SR: rbyte = serial_shifter;
      `DTSS_OFF_ACR: rbyte = aux_control_reg;
      `DTSS_OFF_IFR: rbyte = interrupt_flag_reg;
      default: rbyte = `DTSS_BYTE_RST;
    endcase
  end

  // Read data is held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= {24'h00_0000, rbyte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_b_output_reg <= `DTSS_BYTE_RST;
      port_b_direction_reg <= `DTSS_BYTE_RST;
      aux_control_reg <= `DTSS_BYTE_RST;
      first_timer_latch_low <= `DTSS_BYTE_RST;
      first_timer_latch_high <= `DTSS_BYTE_RST;
      second_timer_latch_low <= `DTSS_BYTE_RST;
    end else begin
      if (hit(wb_adr_i, `DTSS_OFF_ORB, wr)) port_b_output_reg <= wbyte;
      if (hit(wb_adr_i, `DTSS_OFF_PORT_B_DIRECTION_REG, wr)) port_b_direction_reg <= wbyte;
      if (hit(wb_adr_i, `DTSS_OFF_ACR, wr)) aux_control_reg <= wbyte; // R23

      // Writes to low count and low latch both land in the low latch
      if (hit(wb_adr_i, `DTSS_OFF_T1CL, wr) || hit(wb_adr_i, `DTSS_OFF_T1LL, wr))
        first_timer_latch_low <= wbyte; // R09
      if (hit(wb_adr_i, `DTSS_OFF_T1LH, wr) || hit(wb_adr_i, `DTSS_OFF_T1CH, wr))
        first_timer_latch_high <= wbyte; // R06
      if (hit(wb_adr_i, `DTSS_OFF_T2CL, wr)) second_timer_latch_low <= wbyte; // R26
    end
  end

  // Mode fields of the aux control register
  assign mode.pin_enable = aux_control_reg[`DTSS_ACR_T1PIN];
  assign mode.free_run = aux_control_reg[`DTSS_ACR_T1FREE];
  assign mode.t2_pulse = aux_control_reg[`DTSS_ACR_T2PULSE]; // R11
  assign mode.sr_mode = aux_control_reg[`DTSS_ACR_SRM_HI:`DTSS_ACR_SRM_LO];

  ////////////////////////////////////////////////////////////////////////////
  // First timer
  logic t1_load;
  assign t1_load = hit(wb_adr_i, `DTSS_OFF_T1CH, wr) || (t1_zero && mode.free_run);

  assign t1_timeout = t1_zero && t1_armed_reg;

  dtss_timer16 u_t1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(t1_load), // R02 R03 R07 R25
    .load_value_i(hit(wb_adr_i, `DTSS_OFF_T1CH, wr) ? {wbyte, first_timer_latch_low}
                                                    : {first_timer_latch_high, first_timer_latch_low}),
    .dec_i(1'b1), // R01
    .count_o(t1_count),
    .zero_o(t1_zero)
  );

  // A restart wins over a time-out in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t1_armed_reg <= 1'b0;
      t1_pin_reg <= 1'b1;
    end else if (hit(wb_adr_i, `DTSS_OFF_T1CH, wr)) begin
      t1_armed_reg <= 1'b1; // R09
      t1_pin_reg <= 1'b0; // R05
    end else if (t1_timeout) begin
      t1_armed_reg <= mode.free_run; // R04
      t1_pin_reg <= mode.free_run ? !t1_pin_reg : 1'b1; // R05 R07
    end
  end

  // Timer drives the top pin only when both enables are set
  assign port_b_top_pin_o = (port_b_direction_reg[`DTSS_PB_TOP] && mode.pin_enable) ? t1_pin_reg
                            : port_b_output_reg[`DTSS_PB_TOP]; // R10
  assign port_b_top_pin_oe_o = port_b_direction_reg[`DTSS_PB_TOP];

  ////////////////////////////////////////////////////////////////////////////
  // Second timer
  always_ff @(posedge clk_i) begin
    if (rst_i) pb6_d_reg <= 1'b1;
    else pb6_d_reg <= pb6_s;
  end
  // Falling pulse seen on the synchronised pin
  assign t2_dec = mode.t2_pulse ? (pb6_d_reg && !pb6_s) : 1'b1; // R15 R16

  assign t2_timeout = t2_zero && t2_dec && t2_armed_reg;

  dtss_timer16 u_t2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(hit(wb_adr_i, `DTSS_OFF_T2CH, wr)), // R25 R26
    .load_value_i({wbyte, second_timer_latch_low}),
    .dec_i(t2_dec), // R12
    .count_o(t2_count),
    .zero_o(t2_zero)
  );

  // In pulse mode a time-out needs a counted pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) t2_armed_reg <= 1'b0;
    else if (hit(wb_adr_i, `DTSS_OFF_T2CH, wr)) t2_armed_reg <= 1'b1;
    else if (t2_timeout) t2_armed_reg <= 1'b0; // R13 R15
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial shifter
  assign sr_access = hit(wb_adr_i, `DTSS_OFF_SR, req);

  // Both edge detectors start at the idle-high pin level
  always_ff @(posedge clk_i) begin
    if (rst_i) cb1_d_reg <= 1'b1;
    else cb1_d_reg <= cb1_s;
  end

  // Half period of the generated shift clock: N+2 cycles
  assign sh_tick = (t2_half_reg == `DTSS_BYTE_RST);

  // The bit count wraps to zero on the eighth bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_state_reg <= dtss_pkg::DTSS_SH_IDLE;
      sh_count_reg <= 3'h0;
      sh_clk_reg <= 1'b1;
      sh_sample_reg <= 1'b0;
      t2_half_reg <= `DTSS_BYTE_RST;
    end else begin
      sh_sample_reg <= 1'b0;

      if (mode.sr_mode != `DTSS_SRM_T2IN) begin
        sh_state_reg <= dtss_pkg::DTSS_SH_IDLE;
        sh_clk_reg <= 1'b1;
      end else if (sr_access) begin
        sh_count_reg <= 3'h0; // R17
        sh_clk_reg <= 1'b1;
        t2_half_reg <= second_timer_latch_low + 8'h01; // R20
        sh_state_reg <= interrupt_flag_reg[`DTSS_IFR_SR] ? dtss_pkg::DTSS_SH_RUN
                                                         : dtss_pkg::DTSS_SH_WAIT; // R21
      end else begin
        case (sh_state_reg)
          dtss_pkg::DTSS_SH_IDLE: sh_clk_reg <= 1'b1;
          dtss_pkg::DTSS_SH_WAIT: begin
            if (t2_timeout || (t2_zero && t2_dec)) sh_state_reg <= dtss_pkg::DTSS_SH_RUN; // R21
          end
          dtss_pkg::DTSS_SH_RUN: begin
            if (sh_tick) begin
              t2_half_reg <= second_timer_latch_low + 8'h01;
              sh_clk_reg <= !sh_clk_reg; // R20
              if (!sh_clk_reg) begin
                sh_sample_reg <= 1'b1; // R22
                sh_count_reg <= sh_count_reg + 3'h1;
                if (sh_count_reg == `DTSS_BITS_PER_BYTE) sh_state_reg <= dtss_pkg::DTSS_SH_IDLE;
              end
            end else begin
              t2_half_reg <= t2_half_reg - 8'h01;
            end
          end
          default: sh_state_reg <= dtss_pkg::DTSS_SH_IDLE;
        endcase
      end
    end
  end

  // Clock line is driven whenever mode 1 is selected, idle or shifting
  assign port_b_shift_clock_line_o = sh_clk_reg;
  assign port_b_shift_clock_line_oe_o = (mode.sr_mode == `DTSS_SRM_T2IN); // R18

  logic sh_shift;
  assign sh_shift = (mode.sr_mode == `DTSS_SRM_EXT) ? (cb1_s && !cb1_d_reg) : sh_sample_reg; // R19 R22

  always_ff @(posedge clk_i) begin
    if (rst_i) serial_shifter <= `DTSS_BYTE_RST;
    else if (hit(wb_adr_i, `DTSS_OFF_SR, wr)) serial_shifter <= wbyte;
    else if (sh_shift) serial_shifter <= {serial_shifter[6:0], cb2_s}; // R17
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a hardware set wins over any clearing access in the same cycle; mode 0 holds the shifter flag at zero over a set
  // Done when the eighth sample leaves the count wrapped and the state idle
  logic sr_done;
  assign sr_done = sh_sample_reg && (sh_count_reg == 3'h0)
                   && (sh_state_reg == dtss_pkg::DTSS_SH_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_flag_reg <= `DTSS_BYTE_RST;
    end else begin
      if (t1_timeout) interrupt_flag_reg[`DTSS_IFR_T1] <= 1'b1; // R04 R07
      else if (hit(wb_adr_i, `DTSS_OFF_T1CH, wr) || hit(wb_adr_i, `DTSS_OFF_T1LH, wr) ||
               hit(wb_adr_i, `DTSS_OFF_T1CL, rd) ||
               (hit(wb_adr_i, `DTSS_OFF_IFR, wr) && wbyte[`DTSS_IFR_T1]))
        interrupt_flag_reg[`DTSS_IFR_T1] <= 1'b0; // R08 R24

      if (t2_timeout) interrupt_flag_reg[`DTSS_IFR_T2] <= 1'b1; // R13 R15
      else if (hit(wb_adr_i, `DTSS_OFF_T2CH, wr) || hit(wb_adr_i, `DTSS_OFF_T2CL, rd) ||
               (hit(wb_adr_i, `DTSS_OFF_IFR, wr) && wbyte[`DTSS_IFR_T2]))
        interrupt_flag_reg[`DTSS_IFR_T2] <= 1'b0; // R14 R24

      if (mode.sr_mode == `DTSS_SRM_EXT) interrupt_flag_reg[`DTSS_IFR_SR] <= 1'b0; // R19
      else if (sr_done) interrupt_flag_reg[`DTSS_IFR_SR] <= 1'b1; // R22
      else if (sr_access || (hit(wb_adr_i, `DTSS_OFF_IFR, wr) && wbyte[`DTSS_IFR_SR]))
        interrupt_flag_reg[`DTSS_IFR_SR] <= 1'b0; // R24
    end
  end

  assign t1_flag_t2_flag_sr_flag_o = interrupt_flag_reg;
endmodule // dtss_top
